// ===== dv/ibx_mem_model.sv
// Data memory and bit space at the far side of the executor
module ibx_mem_model (
   input  wire logic       core_clk_i,
   input  wire logic [7:0] mem_addr_i,
   input  wire logic       mem_rd_i,
   input  wire logic       mem_we_i,
   input  wire logic [7:0] mem_wdata_i,
   output logic [7:0]      mem_rdata_o,
   input  wire logic [7:0] bit_addr_i,
   input  wire logic       bit_rd_i,
   output logic            bit_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [256];
   logic [7:0] noise;
   initial begin
      noise = 8'h00;
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i) ^ 8'h5a;
      end
   end
   // Unstrobed read data churns every cycle
   always @(posedge core_clk_i) begin
      noise <= noise + 8'h3b;
      if (mem_we_i) begin
         mem[mem_addr_i] <= mem_wdata_i;
      end
   end
   assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i] : noise;
   // Read-only bits derived from the address
   assign bit_o = bit_rd_i ? (bit_addr_i[0] ^ bit_addr_i[4]) : noise[0];
endmodule : ibx_mem_model

// ===== dv/incr_and_branch_exec_tb.sv
// Self-checking bench of the increment and branch executor
`define CHK(nm, ex, gt) begin samples_checked++; if (64'(gt) !== 64'(ex)) begin \
   err_count++; $display("MISMATCH %s expected %h seen %h", nm, 64'(ex), 64'(gt)); end end
module incr_and_branch_exec_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk_i = 0;
   logic        rst_i = 1;
   logic        instr_valid_i = 0;
   logic [7:0]  opcode_i = 8'h00;
   logic [7:0]  operand_a_i = 8'h00;
   logic [7:0]  operand_b_i = 8'h00;
   logic [15:0] instr_pc_i = 16'h0000;
   logic        preset_we_i = 0;
   logic [3:0]  preset_sel_i = 4'h0;
   logic [7:0]  preset_data_i = 8'h00;
   logic        instr_ready_o, done_o, branch_taken_o, unsupported_o, mem_rd_o, mem_we_o;
   logic        bit_rd_o, bit_i, parity_o;
   logic [15:0] next_pc_o, data_pointer_16_o;
   logic [7:0]  mem_addr_o, mem_wdata_o, mem_rdata_i, bit_addr_o, acc_o;
   logic [63:0] working_register_o;
   int          err_count = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   int          acc = 0;
   int          dp = 0;
   int          regs [8] = '{default: 0};
   int          mem [256];
   logic [7:0]  ops [17] = '{8'hd5, 8'h06, 8'h07, 8'h04, 8'ha3, 8'h08, 8'h09, 8'h0a, 8'h0b,
                             8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h05, 8'h20, 8'h00, 8'h14};
   ibx_exec dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
      .instr_ready_o(instr_ready_o), .opcode_i(opcode_i), .operand_a_i(operand_a_i),
      .operand_b_i(operand_b_i), .instr_pc_i(instr_pc_i), .done_o(done_o),
      .branch_taken_o(branch_taken_o), .unsupported_o(unsupported_o), .next_pc_o(next_pc_o),
      .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_we_o(mem_we_o),
      .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .bit_addr_o(bit_addr_o),
      .bit_rd_o(bit_rd_o), .bit_i(bit_i), .preset_we_i(preset_we_i),
      .preset_sel_i(preset_sel_i), .preset_data_i(preset_data_i), .acc_o(acc_o),
      .parity_o(parity_o), .data_pointer_16_o(data_pointer_16_o),
      .working_register_o(working_register_o));
   ibx_mem_model partner (.core_clk_i(core_clk_i), .mem_addr_i(mem_addr_o),
      .mem_rd_i(mem_rd_o), .mem_we_i(mem_we_o), .mem_wdata_i(mem_wdata_o),
      .mem_rdata_o(mem_rdata_i), .bit_addr_i(bit_addr_o), .bit_rd_i(bit_rd_o), .bit_o(bit_i));
   initial begin
      forever #4 core_clk_i = ~core_clk_i;
   end
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         end_sim();
      end
   end
   task automatic check_state();
      `CHK("acc", acc, acc_o)
      `CHK("parity", ^(8'(acc)), parity_o)
      `CHK("pointer", dp, data_pointer_16_o)
      for (int i = 0; i < 8; i++) begin
         `CHK("register", regs[i], working_register_o[8*i +: 8])
      end
   endtask : check_state
   // Leaves the load strobe up; the next instruction lowers it
   task automatic preset(input logic [3:0] sel, input logic [7:0] d);
      preset_we_i = 1;
      preset_sel_i = sel;
      preset_data_i = d;
      @(posedge core_clk_i);
      #1;
      if (sel < 8) regs[sel[2:0]] = d;
      else if (sel == ibx_pkg::SEL_ACC) acc = d;
      else if (sel == ibx_pkg::SEL_PTR_LO) dp = (dp & 'hff00) | d;
      else dp = (dp & 'hff) | (int'(d) << 8);
   endtask : preset
   task automatic run(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b,
                      input logic [15:0] pc);
      int ln, nc, adr, dl, tk, wv, npc, k;
      bit mop, sup;
      ln = 1;
      nc = 1;
      adr = a;
      dl = 1;
      tk = 0;
      mop = 0;
      sup = 1;
      if (op == ibx_pkg::OPC_DEC_BRANCH_NZ) begin
         ln = 3;
         nc = 2;
         mop = 1;
         dl = 255;
      end else if ((op & ibx_pkg::MASK_INDIRECT) == ibx_pkg::OPC_INC_INDIRECT) begin
         mop = 1;
         adr = regs[op[0]];
      end else if (op == ibx_pkg::OPC_INC_DIRECT) begin
         ln = 2;
         mop = 1;
      end else if (op == ibx_pkg::OPC_INC_ACC) begin
         acc = (acc + 1) % 256;
      end else if (op == ibx_pkg::OPC_INC_POINTER) begin
         nc = 2;
         dp = (dp + 1) % 65536;
      end else if ((op & ibx_pkg::MASK_REG) == ibx_pkg::OPC_INC_REG) begin
         regs[op[2:0]] = (regs[op[2:0]] + 1) % 256;
      end else if (op == ibx_pkg::OPC_BRANCH_BIT) begin
         ln = 3;
         nc = 2;
         tk = a[0] ^ a[4];
      end else begin
         sup = 0;
      end
      wv = (mem[adr] + dl) % 256;
      if (mop) mem[adr] = wv;
      if (op == ibx_pkg::OPC_DEC_BRANCH_NZ) tk = (wv != 0);
      npc = (int'(pc) + ln + (tk ? int'($signed(b)) : 0)) & 'hffff;
      preset_we_i = 0;
      opcode_i = op;
      operand_a_i = a;
      operand_b_i = b;
      instr_pc_i = pc;
      instr_valid_i = 1;
      k = 0;
      while (instr_ready_o !== 1'b1 && k < 10) begin
         @(posedge core_clk_i);
         #1;
         k++;
      end
      @(posedge core_clk_i);
      #1;
      instr_valid_i = 0;
      `CHK("busy", 0, instr_ready_o)
      `CHK("mem_rd", mop, mem_rd_o)
      `CHK("mem_we", mop, mem_we_o)
      if (mop) begin
         `CHK("mem_addr", adr, mem_addr_o)
         `CHK("mem_wdata", wv, mem_wdata_o)
      end
      `CHK("bit_rd", op == ibx_pkg::OPC_BRANCH_BIT, bit_rd_o)
      if (op == ibx_pkg::OPC_BRANCH_BIT) `CHK("bit_addr", a, bit_addr_o)
      k = 0;
      while (done_o !== 1'b1 && k < 8) begin
         @(posedge core_clk_i);
         #1;
         k++;
      end
      `CHK("cycles", nc, k)
      `CHK("ready", 1, instr_ready_o)
      `CHK("next_pc", npc, next_pc_o)
      `CHK("taken", tk, branch_taken_o)
      `CHK("unsupported", !sup, unsupported_o)
      check_state();
   endtask : run
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = i ^ 'h5a;
      void'($urandom(32'h8760));
      repeat (12) @(posedge core_clk_i);
      #1;
      rst_i = 0;
      `CHK("ready", 1, instr_ready_o)
      `CHK("next_pc", 0, next_pc_o)
      check_state();
      $display("test reset done");
      for (int i = 0; i < 8; i++) preset(4'(i), 8'($urandom));
      preset(ibx_pkg::SEL_ACC, 8'hff);
      preset(ibx_pkg::SEL_PTR_LO, 8'hff);
      preset(ibx_pkg::SEL_PTR_HI, 8'hff);
      run(ibx_pkg::OPC_INC_ACC, 8'h00, 8'h00, 16'h0100);
      run(ibx_pkg::OPC_INC_POINTER, 8'h00, 8'h00, 16'h0101);
      preset(ibx_pkg::SEL_PTR_HI, 8'h12);
      preset(ibx_pkg::SEL_PTR_LO, 8'hff);
      run(ibx_pkg::OPC_INC_POINTER, 8'h00, 8'h00, 16'h0102);
      $display("test wrap done");
      run(ibx_pkg::OPC_DEC_BRANCH_NZ, 8'h5b, 8'h10, 16'hfffe);
      run(ibx_pkg::OPC_DEC_BRANCH_NZ, 8'h5b, 8'h80, 16'h0040);
      run(ibx_pkg::OPC_DEC_BRANCH_NZ, 8'h5b, 8'h7f, 16'hff90);
      run(ibx_pkg::OPC_INC_DIRECT, 8'ha5, 8'h00, 16'hffff);
      run(ibx_pkg::OPC_BRANCH_BIT, 8'h01, 8'hf0, 16'h0003);
      run(ibx_pkg::OPC_BRANCH_BIT, 8'h11, 8'hf0, 16'h0003);
      $display("test branch done");
      foreach (ops[i]) run(ops[i], 8'($urandom), 8'($urandom), 16'($urandom));
      for (int i = 0; i < 60; i++) begin
         run(ops[$urandom % 17], 8'($urandom), 8'($urandom), 16'($urandom));
      end
      $display("test random done");
      end_sim();
   end
endmodule : incr_and_branch_exec_tb

// ===== shared/ibx_pkg.sv
// Constants, opcodes and state codes of the increment and branch executor
package ibx_pkg;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned PC_W   = 16;
   localparam int unsigned SEL_W  = 4;
   localparam int unsigned NREGS  = 8;

   localparam logic [7:0] OPC_DEC_BRANCH_NZ = 8'hd5;
   localparam logic [7:0] OPC_INC_INDIRECT  = 8'h06;
   localparam logic [7:0] MASK_INDIRECT     = 8'hfe;
   localparam logic [7:0] OPC_INC_ACC       = 8'h04;
   localparam logic [7:0] OPC_INC_POINTER   = 8'ha3;
   localparam logic [7:0] OPC_INC_REG       = 8'h08;
   localparam logic [7:0] MASK_REG          = 8'hf8;
   localparam logic [7:0] OPC_INC_DIRECT    = 8'h05;
   localparam logic [7:0] OPC_BRANCH_BIT    = 8'h20;

   localparam logic [15:0] LEN_ONE   = 16'h0001;
   localparam logic [15:0] LEN_TWO   = 16'h0002;
   localparam logic [15:0] LEN_THREE = 16'h0003;

   localparam logic [7:0]  BYTE_RESET = 8'h00;
   localparam logic [15:0] PC_RESET   = 16'h0000;

   localparam logic [3:0] SEL_ACC    = 4'h8;
   localparam logic [3:0] SEL_PTR_LO = 4'h9;
   localparam logic [3:0] SEL_PTR_HI = 4'ha;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_EXEC1 = 3'b010,
      ST_EXEC2 = 3'b100
   } ibx_state_type;
endpackage : ibx_pkg

// ===== shared/ibx_step_if.sv
// Carrier between the executor and its step unit
interface ibx_step_if #(parameter int unsigned WIDTH = 8);
   logic [WIDTH-1:0] a;
   logic             dec;
   logic             cin;
   logic [WIDTH-1:0] y;
   logic             cout;
   modport user (output a, output dec, output cin, input y, input cout);
   modport unit (input a, input dec, input cin, output y, output cout);
endinterface : ibx_step_if

// ===== src/ibx_exec.sv
// Increment and relative branch executor
// How it works
// RQ1: Memory decrement-branch is three bytes, two execute cycles.
// RQ2: Decrement the direct byte, write back, branch when result nonzero.
// RQ3: Zero result falls through to the address after the three bytes.
// RQ4: Indirect increment uses opcode bit 0 to pick register 0 or 1.
// RQ5: Accumulator increment takes one cycle and refreshes the parity flag.
// RQ6: Pointer increment carries low into high byte over two cycles.
// RQ7: Register increment adds one to the selected one of eight registers.
// RQ8: Direct increment adds one to the byte named by the second byte.
// RQ9: Bit branch is three bytes, two cycles, branches on one, bit kept.
// RQ10: Target is next instruction address plus signed offset byte.
// RQ11: Byte steps wrap modulo 256, pointer wraps from all ones to zero.
module ibx_exec (
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        instr_valid_i,
   output logic             instr_ready_o,
   input  wire logic [7:0]  opcode_i,
   input  wire logic [7:0]  operand_a_i,
   input  wire logic [7:0]  operand_b_i,
   input  wire logic [15:0] instr_pc_i,
   output logic             done_o,
   output logic             branch_taken_o,
   output logic             unsupported_o,
   output logic [15:0]      next_pc_o,
   output logic [7:0]       mem_addr_o,
   output logic             mem_rd_o,
   output logic             mem_we_o,
   output logic [7:0]       mem_wdata_o,
   input  wire logic [7:0]  mem_rdata_i,
   output logic [7:0]       bit_addr_o,
   output logic             bit_rd_o,
   input  wire logic        bit_i,
   input  wire logic        preset_we_i,
   input  wire logic [3:0]  preset_sel_i,
   input  wire logic [7:0]  preset_data_i,
   output logic [7:0]       acc_o,
   output logic             parity_o,
   output logic [15:0]      data_pointer_16_o,
   output logic [63:0]      working_register_o
);
   ibx_pkg::ibx_state_type state;
   ibx_pkg::ibx_state_type next_state;
   logic [7:0]  op_q, next_op_q, opa_q, next_opa_q, opb_q, next_opb_q;
   logic [15:0] pc_q, next_pc_q, next_next_pc;
   logic        cond_q, next_cond_q, carry_q, next_carry_q;
   logic        next_done, next_taken, next_unsupported;
   logic [7:0]  acc, next_acc;
   logic        next_parity;
   logic [15:0] pointer, next_pointer;
   logic [7:0]  wreg [ibx_pkg::NREGS];
   logic [7:0]  next_wreg [ibx_pkg::NREGS];
   logic        is_dec_br, is_ind, is_acc, is_ptr, is_reg, is_dir, is_bit_br, two_cycle;
   logic        exec1, exec2, accept;
   logic [15:0] inst_len, pc_after, target;
   logic [7:0]  sel_reg_val;

   ibx_step_if #(.WIDTH(ibx_pkg::BYTE_W)) step_bus ();
   ibx_step #(.WIDTH(ibx_pkg::BYTE_W)) u_step (.sif(step_bus));

   // Decode of the held opcode
   assign is_dec_br = op_q == ibx_pkg::OPC_DEC_BRANCH_NZ;
   assign is_ind    = (op_q & ibx_pkg::MASK_INDIRECT) == ibx_pkg::OPC_INC_INDIRECT;
   assign is_acc    = op_q == ibx_pkg::OPC_INC_ACC;
   assign is_ptr    = op_q == ibx_pkg::OPC_INC_POINTER;
   assign is_reg    = (op_q & ibx_pkg::MASK_REG) == ibx_pkg::OPC_INC_REG;
   assign is_dir    = op_q == ibx_pkg::OPC_INC_DIRECT;
   assign is_bit_br = op_q == ibx_pkg::OPC_BRANCH_BIT;
   assign two_cycle = is_dec_br | is_ptr | is_bit_br;    // see RQ1, RQ6, RQ9
   assign exec1     = state == ibx_pkg::ST_EXEC1;
   assign exec2     = state == ibx_pkg::ST_EXEC2;
   assign instr_ready_o = state == ibx_pkg::ST_IDLE;
   assign accept    = instr_valid_i & instr_ready_o;
   assign sel_reg_val = wreg[op_q[2:0]];

   // Instruction length and branch target
   always_comb begin
      if (is_dec_br || is_bit_br) begin
         inst_len = ibx_pkg::LEN_THREE;                  // see RQ1, RQ9
      end else if (is_dir) begin
         inst_len = ibx_pkg::LEN_TWO;                    // see RQ8
      end else begin
         inst_len = ibx_pkg::LEN_ONE;
      end
   end
   assign pc_after = pc_q + inst_len;                    // see RQ3
   assign target   = pc_after + {{(ibx_pkg::PC_W - ibx_pkg::BYTE_W){opb_q[7]}}, opb_q}; // see RQ10

   // Memory and bit access from held operands
   assign mem_addr_o  = is_ind ? wreg[{2'b00, op_q[0]}] : opa_q;     // see RQ4, RQ8
   assign mem_rd_o    = exec1 & (is_dec_br | is_ind | is_dir);
   assign mem_we_o    = mem_rd_o;                                     // see RQ2
   assign mem_wdata_o = step_bus.y;
   assign bit_addr_o  = opa_q;
   assign bit_rd_o    = exec1 & is_bit_br;                            // see RQ9

   // Step operand selection
   always_comb begin
      step_bus.a   = mem_rdata_i;
      step_bus.dec = is_dec_br;                          // see RQ2
      step_bus.cin = 1'b1;
      if (is_acc) begin
         step_bus.a = acc;                               // see RQ5
      end else if (is_reg) begin
         step_bus.a = sel_reg_val;                       // see RQ7
      end else if (is_ptr) begin
         step_bus.a   = exec2 ? pointer[15:8] : pointer[7:0];
         step_bus.cin = exec2 ? carry_q : 1'b1;          // see RQ6, RQ11
      end
   end

   // Sequencer next values
   always_comb begin
      next_state       = state;
      next_op_q        = op_q;
      next_opa_q       = opa_q;
      next_opb_q       = opb_q;
      next_pc_q        = pc_q;
      next_cond_q      = cond_q;
      next_carry_q     = carry_q;
      next_done        = 1'b0;
      next_taken       = branch_taken_o;
      next_unsupported = unsupported_o;
      next_next_pc     = next_pc_o;
      case (state)
         ibx_pkg::ST_IDLE: begin
            if (instr_valid_i) begin
               next_op_q  = opcode_i;
               next_opa_q = operand_a_i;
               next_opb_q = operand_b_i;
               next_pc_q  = instr_pc_i;
               next_state = ibx_pkg::ST_EXEC1;
            end
         end
         ibx_pkg::ST_EXEC1: begin
            next_cond_q  = is_bit_br ? bit_i : (step_bus.y != ibx_pkg::BYTE_RESET); // see RQ2, RQ9
            next_carry_q = step_bus.cout;                // see RQ6
            if (two_cycle) begin
               next_state = ibx_pkg::ST_EXEC2;
            end else begin
               next_state       = ibx_pkg::ST_IDLE;
               next_done        = 1'b1;
               next_taken       = 1'b0;
               next_next_pc     = pc_after;
               next_unsupported = ~(is_ind | is_acc | is_reg | is_dir);
            end
         end
         ibx_pkg::ST_EXEC2: begin
            next_state       = ibx_pkg::ST_IDLE;
            next_done        = 1'b1;
            next_unsupported = 1'b0;
            next_taken       = (is_dec_br | is_bit_br) & cond_q;     // see RQ2, RQ3, RQ9
            next_next_pc     = next_taken ? target : pc_after;       // see RQ3, RQ10
         end
         default: begin
            next_state = ibx_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state          <= ibx_pkg::ST_IDLE;
         op_q           <= ibx_pkg::BYTE_RESET;
         opa_q          <= ibx_pkg::BYTE_RESET;
         opb_q          <= ibx_pkg::BYTE_RESET;
         pc_q           <= ibx_pkg::PC_RESET;
         cond_q         <= 1'b0;
         carry_q        <= 1'b0;
         done_o         <= 1'b0;
         branch_taken_o <= 1'b0;
         unsupported_o  <= 1'b0;
         next_pc_o      <= ibx_pkg::PC_RESET;
      end else begin
         state          <= next_state;
         op_q           <= next_op_q;
         opa_q          <= next_opa_q;
         opb_q          <= next_opb_q;
         pc_q           <= next_pc_q;
         cond_q         <= next_cond_q;
         carry_q        <= next_carry_q;
         done_o         <= next_done;
         branch_taken_o <= next_taken;
         unsupported_o  <= next_unsupported;
         next_pc_o      <= next_next_pc;
      end
   end

   // Architectural state next values
   always_comb begin
      next_acc     = acc;
      next_parity  = parity_o;
      next_pointer = pointer;
      next_wreg    = wreg;
      if (instr_ready_o && preset_we_i) begin
         if (preset_sel_i == ibx_pkg::SEL_ACC) begin
            next_acc    = preset_data_i;
            next_parity = ^preset_data_i;
         end else if (preset_sel_i == ibx_pkg::SEL_PTR_LO) begin
            next_pointer[7:0] = preset_data_i;
         end else if (preset_sel_i == ibx_pkg::SEL_PTR_HI) begin
            next_pointer[15:8] = preset_data_i;
         end else if (!preset_sel_i[3]) begin
            next_wreg[preset_sel_i[2:0]] = preset_data_i;
         end
      end
      if (exec1 && is_acc) begin
         next_acc    = step_bus.y;                       // see RQ5, RQ11
         next_parity = ^step_bus.y;                      // see RQ5
      end
      if (exec1 && is_reg) begin
         next_wreg[op_q[2:0]] = step_bus.y;              // see RQ7, RQ11
      end
      if (exec1 && is_ptr) begin
         next_pointer[7:0] = step_bus.y;                 // see RQ6
      end
      if (exec2 && is_ptr) begin
         next_pointer[15:8] = step_bus.y;                // see RQ6, RQ11
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         acc      <= ibx_pkg::BYTE_RESET;
         parity_o <= 1'b0;
         pointer  <= ibx_pkg::PC_RESET;
         for (int i = 0; i < ibx_pkg::NREGS; i++) begin
            wreg[i] <= ibx_pkg::BYTE_RESET;
         end
      end else begin
         acc      <= next_acc;
         parity_o <= next_parity;
         pointer  <= next_pointer;
         wreg     <= next_wreg;
      end
   end

   assign acc_o             = acc;
   assign data_pointer_16_o = pointer;
   always_comb begin
      for (int i = 0; i < ibx_pkg::NREGS; i++) begin
         working_register_o[i*8 +: 8] = wreg[i];
      end
   end

   // Checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_two_exec;
      ##1 exec1 ##1 exec2 ##1 done_o;
   endsequence
   sequence s_one_exec;
      ##1 exec1 ##1 done_o;
   endsequence

   AST_DEC_BRANCH_TIME: assert property ( // see RQ1
      accept && opcode_i == ibx_pkg::OPC_DEC_BRANCH_NZ
      |-> s_two_exec ##0 (next_pc_o == $past(instr_pc_i, 3) + 16'h0003 || branch_taken_o))
      else $error("dec-branch length or timing wrong");
   AST_DEC_BRANCH_WRITE: assert property (exec1 && is_dec_br // see RQ2
      |-> mem_we_o && mem_wdata_o == mem_rdata_i - 8'h01)
      else $error("dec-branch write back wrong");
   AST_DEC_BRANCH_ZERO: assert property (exec1 && is_dec_br && mem_rdata_i == 8'h01 // see RQ3
      |-> ##2 done_o && !branch_taken_o && next_pc_o == pc_q + 16'h0003)
      else $error("dec-branch zero did not fall through");
   AST_INC_IND: assert property (exec1 && is_ind // see RQ4
      |-> mem_we_o && mem_addr_o == wreg[{2'b00, op_q[0]}]
          && mem_wdata_o == mem_rdata_i + 8'h01)
      else $error("indirect increment wrong");
   AST_INC_ACC: assert property (accept && opcode_i == ibx_pkg::OPC_INC_ACC // see RQ5
      |-> s_one_exec ##0 (acc_o == $past(acc_o) + 8'h01 && parity_o == ^acc_o))
      else $error("accumulator increment wrong");
   AST_PTR_INC: assert property (accept && opcode_i == ibx_pkg::OPC_INC_POINTER // see RQ6
      |-> s_two_exec ##0 data_pointer_16_o == $past(data_pointer_16_o, 2) + 16'h0001)
      else $error("pointer increment wrong");
   AST_INC_REG: assert property (exec1 && is_reg // see RQ7
      |=> done_o && sel_reg_val == $past(sel_reg_val) + 8'h01)
      else $error("register increment wrong");
   AST_INC_DIR: assert property (accept && opcode_i == ibx_pkg::OPC_INC_DIRECT // see RQ8
      |=> mem_we_o && mem_addr_o == $past(operand_a_i) ##1 done_o
          && next_pc_o == pc_q + 16'h0002)
      else $error("direct increment wrong");
   AST_BIT_BRANCH: assert property (exec1 && is_bit_br // see RQ9
      |-> !mem_we_o ##1 exec2 ##1 (done_o && branch_taken_o == $past(bit_i, 2)))
      else $error("bit branch decision wrong");
   AST_TARGET: assert property (done_o && branch_taken_o // see RQ10
      |-> next_pc_o == pc_q + inst_len + {{8{opb_q[7]}}, opb_q})
      else $error("branch target wrong");
   AST_PTR_WRAP: assert property (exec1 && is_ptr && data_pointer_16_o == 16'hffff // see RQ11
      |-> ##2 data_pointer_16_o == 16'h0000)
      else $error("pointer did not wrap");
endmodule : ibx_exec

// ===== src/ibx_step.sv
// Wrapping add or subtract of a carry-in
module ibx_step #(
   parameter int unsigned WIDTH = 8
) (
   ibx_step_if.unit sif
);
   logic [WIDTH:0] sum;

   always_comb begin
      if (sif.dec) begin
         sum = {1'b0, sif.a} - {{WIDTH{1'b0}}, sif.cin};
      end else begin
         sum = {1'b0, sif.a} + {{WIDTH{1'b0}}, sif.cin};
      end
   end

   assign sif.y    = sum[WIDTH-1:0];
   assign sif.cout = sum[WIDTH];
endmodule : ibx_step
